// file: sim/sbc_slave_model.sv
// bus slave model: bus clock while selected, status per low phase
// assumes it sees the area selects of the bus under test
`timescale 1ns/1ps
`default_nettype none
// ==========
// slave model
module sbc_slave_model (
  input  wire logic                    ref_clk,
  input  wire logic                    rst,
  input  wire logic [7:0]              area_select_n,
  input  wire logic [1:0]              n_wait,
  input  wire logic                    use_hold,
  input  wire logic                    early_last,
  output var  logic                    system_bus_clock,
  output var  sbc_pkg::sbc_status_type slave_status
);
  import sbc_pkg::*;
  logic [2:0] ph_ff;
  logic [1:0] left_ff;
  // clock stands high between frames, 16-cycle period inside them
  always_ff @(posedge ref_clk) begin
    if (rst || &area_select_n) begin
      ph_ff            <= 3'h0;
      system_bus_clock <= 1'b1;
      left_ff          <= n_wait;
      slave_status     <= ~slave_status; // nothing valid while idle
    end else begin
      ph_ff <= ph_ff + 3'h1;
      if (ph_ff == 3'h7) begin
        system_bus_clock <= ~system_bus_clock;
      end
      if (ph_ff == 3'h7 && system_bus_clock) begin
        // answer as the bus clock falls, waits first
        if (left_ff != 2'h0) begin
          // hold keeps wait high until both drop together
          slave_status <= use_hold ? 3'h6 : 3'h4;
          left_ff      <= left_ff - 2'h1;
        end else begin
          // last response cuts a burst short
          slave_status <= early_last ? 3'h1 : 3'h0;
          left_ff      <= n_wait;
        end
      end else if (system_bus_clock || ph_ff == 3'h7) begin
        slave_status <= ~slave_status; // junk while bus clock high
      end
    end
  end
endmodule : sbc_slave_model
`default_nettype wire

// file: sim/tb.sv
// testbench for sbc_ctrl: arbiter, area decode and transfer coding
// assumes the slave model answers on the bus clock it makes
`timescale 1ns/1ps
`default_nettype none
// ==========
// bench top
module tb;
  import sbc_pkg::*;
  logic ref_clk = 0, rst = 1, test_req = 0, ext_req = 0;
  logic misalign_enable_pin = 0, cmd_valid = 0, use_hold = 0, early_last = 0;
  logic [1:0] n_wait = 0;
  sbc_cmd_type cmd = '0;
  logic system_bus_clock, cmd_done_ff, write_direction_ff;
  sbc_status_type slave_status;
  logic [2:0] bus_access_grant_ff, cycle_kind_ff, sequence_code_ff, last_seq;
  logic [7:0] area_select_n_ff;
  logic [ADDR_W-1:0] bus_address_ff, paddr;
  logic [1:0] transfer_kind_ff, transfer_width_ff, pkind = 0;
  logic [3:0] lane_enable_n_ff;
  int n_fail = 0, checks_done = 0, beats, i;
  int area_of[16] = '{0, 0, 2, 2, 1, 1, 3, 3, 4, 4, 6, 6, 6, 7, 7, 5};
  sbc_cmd_type notes[$];
  sbc_cmd_type cur, c;
  always #4 ref_clk = ~ref_clk;
  sbc_ctrl dut (.ref_clk, .rst, .test_req, .ext_req, .misalign_enable_pin,
    .system_bus_clock, .slave_status, .cmd_valid, .cmd, .cmd_done_ff,
    .bus_access_grant_ff, .area_select_n_ff, .bus_address_ff, .transfer_kind_ff,
    .cycle_kind_ff, .lane_enable_n_ff, .transfer_width_ff, .sequence_code_ff,
    .write_direction_ff);
  sbc_slave_model slv (.ref_clk, .rst, .area_select_n(area_select_n_ff),
    .n_wait, .use_hold, .early_last, .system_bus_clock, .slave_status);
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk
  task complete_run;
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run
  // note the expectation, present the command, drop it once done shows
  task do_cmd(input sbc_cmd_type k, input logic mis);
    sbc_cmd_type e;
    int t;
    e = k;
    if (k.cycle == CK_RESERVED || (k.cycle == CK_MISALIGN && !mis)) e.cycle = CK_DATA;
    if (k.width == WD_RESERVED) e.width = WD_WORD;
    notes.push_back(e);
    @(posedge ref_clk);
    cmd <= k;
    misalign_enable_pin <= mis;
    cmd_valid <= 1'b1;
    t = 0;
    // done is read as sampled at the edge; the design takes nothing while done stands
    do begin
      @(posedge ref_clk);
      t++;
    end while (cmd_done_ff !== 1'b1 && t < 12000);
    if (t >= 12000) begin
      n_fail++;
      complete_run();
    end
    cmd_valid <= 1'b0;
  endtask : do_cmd
  // ==========
  // monitor: oldest note against each transfer seen
  always @(posedge ref_clk) if (!rst) begin
    if (transfer_kind_ff == TK_NONSEQ && pkind == TK_ADDR_ONLY) begin
      cur = notes.pop_front();
      beats = 1;
      last_seq = sequence_code_ff;
      chk("area", area_select_n_ff, 8'(~(8'h01 << area_of[cur.addr[BANK_LSB+:4]])));
      chk("address", bus_address_ff, cur.addr);
      chk("seq start", sequence_code_ff, cur.burst);
      chk("cycle", cycle_kind_ff, cur.cycle);
      chk("width", transfer_width_ff, cur.width);
      chk("lanes", lane_enable_n_ff, cur.lanes_n);
      chk("dir", write_direction_ff, cur.write);
      chk("owner", bus_access_grant_ff, GNT_INT);
    end else if (transfer_kind_ff != TK_ADDR_ONLY && bus_address_ff !== paddr) begin
      if (beats >= 2) chk("body seq", last_seq, SQ_RELATED);
      beats++;
      last_seq = sequence_code_ff;
      chk("kind", transfer_kind_ff, TK_SEQ);
      chk("step", 28'(bus_address_ff - paddr), 28'h1 << cur.width);
    end
    if (cmd_done_ff === 1'b1) begin
      chk("beats", beats, early_last ? 1 : (cur.burst < 2 ? cur.burst + 1 : 1 << cur.burst));
      chk("last seq", last_seq, early_last ? cur.burst : SQ_SINGLE);
      chk("idle area", area_select_n_ff, AREA_NONE_N);
      chk("idle kind", transfer_kind_ff, TK_ADDR_ONLY);
    end
    pkind = transfer_kind_ff;
    paddr = bus_address_ff;
  end
  // ==========
  // main sequence
  initial begin
    i = $urandom(32'h4180);
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    test_req <= 1'b1;
    ext_req <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk("grant both", bus_access_grant_ff, GNT_TEST);
    test_req <= 1'b0;
    repeat (8) @(posedge ref_clk);
    chk("grant ext", bus_access_grant_ff, GNT_EXT);
    ext_req <= 1'b0;
    repeat (8) @(posedge ref_clk);
    chk("grant int", bus_access_grant_ff, GNT_INT);
    // every cycle and width code, misalign pin both ways
    for (i = 0; i < 16; i++) begin
      c = '0;
      c.addr = ADDR_W'($urandom);
      c.write = 1'($urandom);
      c.cycle = i[2:0];
      c.width = i[1:0];
      c.lanes_n = 4'($urandom);
      c.burst = 3'($urandom % 4);
      n_wait <= 2'($urandom);
      use_hold <= 1'($urandom);
      do_cmd(c, i[3]);
    end
    // slave cuts the longest burst with a last response on its first beat
    early_last <= 1'b1;
    c.burst = 3'h7;
    do_cmd(c, 1'b0);
    early_last <= 1'b0;
    // higher master holds the bus while a full 128-beat command waits
    test_req <= 1'b1;
    c.burst = 3'h7;
    fork
      do_cmd(c, 1'b0);
      begin
        repeat (30) @(posedge ref_clk);
        chk("held off", transfer_kind_ff, TK_ADDR_ONLY);
        chk("test owns", bus_access_grant_ff, GNT_TEST);
        test_req <= 1'b0;
      end
    join
    complete_run();
  end
  initial begin
    repeat (50000) @(posedge ref_clk);
    n_fail++;
    complete_run();
  end
endmodule : tb
`default_nettype wire

// file: verilog/sbc_ctrl.sv
// arbiter, area decode and master-side transfer signalling of the system bus
// assumes the interior master issues commands on ref_clk; slave status, the
// bus clock and the external request arrive asynchronously on pins
//
// Behaviour
// - exactly one master owns the bus, told by its grant.
// - fixed priority: test controller, then external circuit, then interior.
// - interior gives up the bus when a higher master requests.
// - interior request is always asserted, so it owns an otherwise idle bus.
// - drive the active-low area select of the bank holding the address.
// - transfer kind: 00 address-only, 10 non-sequential, 11 sequential, 01 reserved.
// - cycle kind codes as listed; 101 reserved.
// - misaligned cycle kind only while the misalign pin is high.
// - four active-low lane enables, one per data byte lane.
// - width: 00 byte, 01 halfword, 10 word, 11 reserved.
// - sequence code gives burst length at start, 000 single and final.
// - code 001 for two-beat runs and the body of longer bursts.
// - slave status counts only while the bus clock is low.
// - during address hold, address and controls stay unchanged.
// - direction output high for write, low for read.
`timescale 1ns/1ps
`default_nettype none
module sbc_ctrl (
  input  wire logic                     ref_clk,
  input  wire logic                     rst,
  input  wire logic                     test_req,
  input  wire logic                     ext_req,
  input  wire logic                     misalign_enable_pin,
  input  wire logic                     system_bus_clock,
  input  wire sbc_pkg::sbc_status_type  slave_status,
  input  wire logic                     cmd_valid,
  input  wire sbc_pkg::sbc_cmd_type     cmd,
  output logic                          cmd_done_ff,
  output logic [2:0]                    bus_access_grant_ff,
  output logic [7:0]                    area_select_n_ff,
  output logic [sbc_pkg::ADDR_W-1:0]    bus_address_ff,
  output logic [1:0]                    transfer_kind_ff,
  output logic [2:0]                    cycle_kind_ff,
  output logic [3:0]                    lane_enable_n_ff,
  output logic [1:0]                    transfer_width_ff,
  output logic [2:0]                    sequence_code_ff,
  output logic                          write_direction_ff
);
  import sbc_pkg::*;

  // ==========================================================
  // pin synchronisers
  // three stages; a level counts once stages two and three agree
  logic [SYNC_W-1:0] pin_raw;
  logic [SYNC_W-1:0] sync1_ff;
  logic [SYNC_W-1:0] sync2_ff;
  logic [SYNC_W-1:0] sync3_ff;
  logic [SYNC_W-1:0] pin_ff;
  assign pin_raw = {ext_req, system_bus_clock, slave_status};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          sync1_ff[gi] <= 1'b0;
          sync2_ff[gi] <= 1'b0;
          sync3_ff[gi] <= 1'b0;
          pin_ff[gi]   <= 1'b0;
        end else begin
          sync1_ff[gi] <= pin_raw[gi];
          sync2_ff[gi] <= sync1_ff[gi];
          sync3_ff[gi] <= sync2_ff[gi];
          if (sync2_ff[gi] == sync3_ff[gi]) begin
            pin_ff[gi] <= sync3_ff[gi];
          end
        end
      end
    end
  endgenerate

  logic           ext_req_s;
  logic           bclk_s;
  sbc_status_type stat_s;
  logic           bclk_prev_ff;
  logic           bclk_fall;
  assign ext_req_s = pin_ff[4];
  assign bclk_s    = pin_ff[3];
  assign stat_s    = sbc_status_type'(pin_ff[2:0]);

  // status is judged once per low phase, at the falling edge
  // reset level matches the cleared synchroniser, so no false fall follows reset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bclk_prev_ff <= 1'b0;
    end else begin
      bclk_prev_ff <= bclk_s;
    end
  end
  assign bclk_fall = bclk_prev_ff & ~bclk_s;

  // ==========================================================
  // slave status decode
  // reserved status patterns are treated as wait so the bus never runs away
  logic st_done;
  logic st_last;
  logic st_hold;
  assign st_done = bclk_fall & (stat_s == 3'h0);
  assign st_last = bclk_fall & (stat_s == 3'h1);
  assign st_hold = stat_s.hold_s;

  // ==========================================================
  // arbitration
  sbc_state_type state_ff;
  logic [2:0]    req_vec;
  logic [2:0]    nxt_grant;
  assign req_vec = {1'b1, ext_req_s, test_req};

  // fixed priority, one-hot by construction
  always_comb begin
    if (req_vec[MST_TEST]) begin
      nxt_grant = GNT_TEST;
    end else if (req_vec[MST_EXT]) begin
      nxt_grant = GNT_EXT;
    end else begin
      nxt_grant = GNT_INT;
    end
  end

  // ownership moves only between transfers, so the interior finishes its
  // current beat sequence before yielding
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bus_access_grant_ff <= GNT_INT;
    end else if (state_ff == ST_IDLE) begin
      bus_access_grant_ff <= nxt_grant;
    end
  end

  // ==========================================================
  // command shaping
  logic [2:0] cyc_fix;
  logic [1:0] wid_fix;
  logic [7:0] beats_cmd;
  logic [2:0] seq_first;
  logic [2:0] area_of;
  logic [7:0] incr;
  always_comb begin
    cyc_fix = cmd.cycle;
    if (cmd.cycle == CK_RESERVED) begin
      cyc_fix = CK_DATA;
    end
    if (cmd.cycle == CK_MISALIGN && !misalign_enable_pin) begin
      cyc_fix = CK_DATA;
    end
    wid_fix   = (cmd.width == WD_RESERVED) ? WD_WORD : cmd.width;
    beats_cmd = (cmd.burst == SQ_SINGLE) ? BEATS_ONE : (BEATS_ONE << cmd.burst);
    seq_first = cmd.burst;
    area_of   = 3'(BANK_AREA >> (3 * 32'(cmd.addr[BANK_LSB+:4])));
  end
  assign incr = BEATS_ONE << transfer_width_ff;

  // ==========================================================
  // transfer sequencer
  logic [7:0] beats_left_ff;
  logic       go;
  logic       adv;
  logic       fin;
  assign go  = (state_ff == ST_IDLE) && cmd_valid && (nxt_grant == GNT_INT)
               && (bus_access_grant_ff == GNT_INT)
               && !cmd_done_ff; // valid still stands while done shows: no second take
  assign adv = (state_ff == ST_BUSY) && (st_done || st_last) && !st_hold;
  assign fin = adv && (st_last || beats_left_ff == BEATS_ONE);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_ff <= ST_IDLE;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (go) begin
            state_ff <= ST_BUSY;
          end
        end
        ST_BUSY: begin
          if (fin) begin
            state_ff <= ST_IDLE;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // beat counter
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      beats_left_ff <= BEATS_ONE;
    end else if (go) begin
      beats_left_ff <= beats_cmd;
    end else if (adv) begin
      beats_left_ff <= beats_left_ff - BEATS_ONE;
    end
  end

  // address and control outputs; held while no advance, which covers hold
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      area_select_n_ff   <= AREA_NONE_N;
      bus_address_ff     <= '0;
      transfer_kind_ff   <= TK_ADDR_ONLY;
      cycle_kind_ff      <= CK_DATA;
      lane_enable_n_ff   <= 4'hF;
      transfer_width_ff  <= WD_WORD;
      sequence_code_ff   <= SQ_SINGLE;
      write_direction_ff <= 1'b0;
    end else if (go) begin
      area_select_n_ff   <= ~(8'h01 << area_of);
      bus_address_ff     <= cmd.addr;
      transfer_kind_ff   <= TK_NONSEQ;
      cycle_kind_ff      <= cyc_fix;
      lane_enable_n_ff   <= cmd.lanes_n;
      transfer_width_ff  <= wid_fix;
      sequence_code_ff   <= seq_first;
      write_direction_ff <= cmd.write;
    end else if (fin) begin
      area_select_n_ff   <= AREA_NONE_N;
      transfer_kind_ff   <= TK_ADDR_ONLY;
      sequence_code_ff   <= SQ_SINGLE;
      lane_enable_n_ff   <= 4'hF;
    end else if (adv) begin
      bus_address_ff     <= bus_address_ff + ADDR_W'(incr);
      transfer_kind_ff   <= TK_SEQ;
      // final beat shows 000, body beats 001
      sequence_code_ff   <= (beats_left_ff == 8'h02) ? SQ_SINGLE : SQ_RELATED;
    end
  end

  // one-cycle completion pulse to the interior
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cmd_done_ff <= 1'b0;
    end else begin
      cmd_done_ff <= fin;
    end
  end

  // ==========================================================
  // checks
  sequence s_hold_seen;
    bclk_fall && stat_s.hold_s && state_ff == ST_BUSY;
  endsequence
  sequence s_outputs_kept;
    $stable(bus_address_ff) && $stable(transfer_kind_ff) && $stable(sequence_code_ff);
  endsequence

  a_grant_onehot: assert property (@(posedge ref_clk) disable iff (rst)
    $onehot(bus_access_grant_ff)) else $error("grant not one-hot");
  a_test_first: assert property (@(posedge ref_clk) disable iff (rst)
    (state_ff == ST_IDLE && test_req) |=> bus_access_grant_ff == GNT_TEST)
    else $error("test controller not granted first");
  a_interior_yields: assert property (@(posedge ref_clk) disable iff (rst)
    (state_ff == ST_IDLE && ext_req_s && !test_req) |=> bus_access_grant_ff == GNT_EXT)
    else $error("interior kept bus against external request");
  a_interior_default: assert property (@(posedge ref_clk) disable iff (rst)
    (state_ff == ST_IDLE && !ext_req_s && !test_req) |=> bus_access_grant_ff == GNT_INT)
    else $error("idle bus not given to interior");
  a_one_area: assert property (@(posedge ref_clk) disable iff (rst)
    state_ff == ST_BUSY |-> $onehot(~area_select_n_ff))
    else $error("area select not single during transfer");
  a_kind_legal: assert property (@(posedge ref_clk) disable iff (rst)
    transfer_kind_ff != 2'h1 && cycle_kind_ff != CK_RESERVED
    && transfer_width_ff != WD_RESERVED) else $error("reserved code driven");
  a_misalign_gate: assert property (@(posedge ref_clk) disable iff (rst)
    go && !misalign_enable_pin |=> cycle_kind_ff != CK_MISALIGN)
    else $error("misaligned cycle without enable");
  a_hold_keeps: assert property (@(posedge ref_clk) disable iff (rst)
    s_hold_seen |=> s_outputs_kept) else $error("controls moved during hold");
  a_start_nonseq: assert property (@(posedge ref_clk) disable iff (rst)
    go |=> transfer_kind_ff == TK_NONSEQ && sequence_code_ff == $past(cmd.burst))
    else $error("burst start not flagged");
  a_last_single: assert property (@(posedge ref_clk) disable iff (rst)
    fin |=> transfer_kind_ff == TK_ADDR_ONLY && area_select_n_ff == AREA_NONE_N)
    else $error("bus not released after final beat");
  a_dir_follows: assert property (@(posedge ref_clk) disable iff (rst)
    go |=> write_direction_ff == $past(cmd.write)) else $error("direction wrong");
endmodule : sbc_ctrl
`default_nettype wire

// file: verilog/sbc_pkg.sv
// package for the system bus master/slave signalling block
// assumes one 125 MHz clock and slave status lines arriving from pins
package sbc_pkg;
  // transfer kind codes
  localparam logic [1:0] TK_ADDR_ONLY = 2'h0;
  localparam logic [1:0] TK_NONSEQ    = 2'h2;
  localparam logic [1:0] TK_SEQ       = 2'h3;
  // cycle kind codes
  localparam logic [2:0] CK_DATA      = 3'h1;
  localparam logic [2:0] CK_MISALIGN  = 3'h2;
  localparam logic [2:0] CK_RESERVED  = 3'h5;
  // width codes
  localparam logic [1:0] WD_BYTE      = 2'h0;
  localparam logic [1:0] WD_HALF      = 2'h1;
  localparam logic [1:0] WD_WORD      = 2'h2;
  localparam logic [1:0] WD_RESERVED  = 2'h3;
  // sequence codes
  localparam logic [2:0] SQ_SINGLE    = 3'h0;
  localparam logic [2:0] SQ_RELATED   = 3'h1;
  // master indices and grant vectors
  localparam int        MST_TEST     = 0;
  localparam int        MST_EXT      = 1;
  localparam int        MST_INT      = 2;
  localparam logic [2:0] GNT_TEST     = 3'h1;
  localparam logic [2:0] GNT_EXT      = 3'h2;
  localparam logic [2:0] GNT_INT      = 3'h4;
  // address layout: 16 banks of 4 MB over 64 MB
  localparam int        ADDR_W       = 28;
  localparam int        BANK_LSB     = 22;
  localparam int        SYNC_W       = 5;
  localparam logic [7:0] AREA_NONE_N  = 8'hFF;
  // bank to area map, entry n at bits 3n+2..3n
  localparam logic [47:0] BANK_AREA   = 48'hBFE_DA4_6C9_480;
  localparam logic [7:0] BEATS_ONE    = 8'h01;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              write;
    logic [2:0]        cycle;
    logic [1:0]        width;
    logic [3:0]        lanes_n;
    logic [2:0]        burst;   // 0 single, 1 two beats, 2..7 -> 1<<code beats
  } sbc_cmd_type;

  typedef struct packed {
    logic wait_s;
    logic hold_s;
    logic final_s;
  } sbc_status_type;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_BUSY = 1'b1
  } sbc_state_type;
endpackage : sbc_pkg
